// ===== rtl/cssc_top.sv
// Purpose: Start-up timing and clock switching of the system oscillator
// Assumes: sleep_req comes from core logic on clk; wake and xtal pin are async
// Notes:   Source change is announced by clk_stat only after start-up counts
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// How it works
// - Crystal modes wait 1024 pin oscillations
// - Start-up count restarts after reset, wake
// - Times-four multiplier offered as clock source
// - Reset selection 010 starts on multiplier
// - Runtime write 010 requests multiplier source
// - Sleep during switch abandons the switch
// - Wake without hold: new clock, flag set
// - Wake with hold: old clock, rerequest
// - Priority bits 7,6,1,0; others zero
module cssc_top #(
    parameter int OST_EDGES = cssc_pkg::OST_EDGES
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic [4:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic [2:0]              reset_osc_select,
    input  wire logic [1:0]              osc_mode,
    input  wire logic                    crystal_input_pin,
    input  wire logic                    sleep_req,
    input  wire logic                    wake,
    output cssc_pkg::cssc_clk_stat_t     clk_stat,
    output logic                         sleep_ack,
    output logic [7:0]                   irq_priority,
    output logic                         irq
);

    localparam int CW = $clog2(OST_EDGES + 1);
    localparam logic [CW-1:0] OST_FULL = CW'(OST_EDGES);

    logic                      xtal_meta_ff;
    logic                      xtal_sync_ff;
    logic                      xtal_prev_ff;
    logic                      wake_meta_ff;
    logic                      wake_sync_ff;
    cssc_pkg::cssc_state_t     state_ff;
    logic [2:0]                sel_ff;
    logic [2:0]                req_osc_ff;
    logic [2:0]                tgt_ff;
    logic                      pending_ff;
    logic                      hold_ff;
    logic [1:0]                mode_ff;
    logic                      need_ff;
    logic                      ready_ff;
    logic [CW-1:0]             ost_cnt_ff;
    logic                      sw_evt_ff;
    logic                      rdy_evt_ff;
    logic [cssc_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [cssc_pkg::IRQ_W-1:0] irq_mask_ff;
    logic [7:0]                prio_ff;
    logic [31:0]               rdata_ff;
    logic                      wait_ff;
    cssc_pkg::cssc_clk_stat_t  clk_stat_ff;
    logic                      sleep_ack_ff;
    logic                      irq_ff;

    logic                      xtal_edge;
    logic                      ost_done;
    logic                      wr_ctrl;
    logic [2:0]                new_osc;
    logic [2:0]                wake_tgt;
    logic [cssc_pkg::IRQ_W-1:0] irq_clr;
    logic [cssc_pkg::IRQ_W-1:0] irq_set;

    function automatic logic needs_ost(input logic [2:0] src,
                                       input logic [1:0] mode);
        return (src == cssc_pkg::OSC_EXT_PLL || src == cssc_pkg::OSC_EXT)
            && mode != cssc_pkg::MODE_ECLK;
    endfunction : needs_ost

    // Pin synchronisers; edge detect only reads the second stage onward
    always_ff @(posedge clk) begin
        if (srst) begin
            xtal_meta_ff <= 1'b0;
            xtal_sync_ff <= 1'b0;
            xtal_prev_ff <= 1'b0;
            wake_meta_ff <= 1'b0;
            wake_sync_ff <= 1'b0;
        end else begin
            xtal_meta_ff <= crystal_input_pin;
            xtal_sync_ff <= xtal_meta_ff;
            xtal_prev_ff <= xtal_sync_ff;
            wake_meta_ff <= wake;
            wake_sync_ff <= wake_meta_ff;
        end
    end

    assign xtal_edge = xtal_sync_ff & ~xtal_prev_ff;
    assign ost_done  = !need_ff || (ost_cnt_ff == OST_FULL);
    assign wr_ctrl   = avs_write && !wait_ff
                       && avs_address == cssc_pkg::REG_CTRL;
    assign new_osc   = avs_writedata[cssc_pkg::CTRL_NEW_OSC_SELECT_LSB +: 3];
    assign wake_tgt  = (pending_ff && !hold_ff) ? req_osc_ff : sel_ff;

    // Oscillator sequencing
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff   <= cssc_pkg::ST_INIT;
            sel_ff     <= cssc_pkg::OSC_HFINT;
            req_osc_ff <= cssc_pkg::OSC_HFINT;
            tgt_ff     <= cssc_pkg::OSC_HFINT;
            pending_ff <= 1'b0;
            mode_ff    <= cssc_pkg::MODE_ECLK;
            need_ff    <= 1'b0;
            ready_ff   <= 1'b0;
            ost_cnt_ff <= '0;
            sw_evt_ff  <= 1'b0;
            rdy_evt_ff <= 1'b0;
        end else begin
            sw_evt_ff  <= 1'b0;
            rdy_evt_ff <= 1'b0;
            if (xtal_edge && ost_cnt_ff != OST_FULL) begin
                ost_cnt_ff <= CW'(ost_cnt_ff + 1'b1);
            end
            case (state_ff)
                cssc_pkg::ST_INIT: begin
                    mode_ff    <= osc_mode;
                    tgt_ff     <= reset_osc_select;
                    req_osc_ff <= reset_osc_select;
                    need_ff    <= needs_ost(reset_osc_select, osc_mode);
                    ost_cnt_ff <= '0;
                    state_ff   <= cssc_pkg::ST_START;
                end
                cssc_pkg::ST_START: begin
                    if (ost_done) begin
                        sel_ff     <= tgt_ff;
                        ready_ff   <= 1'b1;
                        rdy_evt_ff <= 1'b1;
                        state_ff   <= cssc_pkg::ST_RUN;
                    end
                end
                cssc_pkg::ST_RUN: begin
                    if (sleep_req) begin
                        ready_ff <= 1'b0;
                        state_ff <= cssc_pkg::ST_SLEEP;
                    end else if (wr_ctrl && new_osc != sel_ff) begin
                        // runtime request of a new source
                        req_osc_ff <= new_osc;
                        tgt_ff     <= new_osc;
                        pending_ff <= 1'b1;
                        need_ff    <= needs_ost(new_osc, mode_ff);
                        ost_cnt_ff <= '0;
                        state_ff   <= cssc_pkg::ST_SWITCH;
                    end
                end
                cssc_pkg::ST_SWITCH: begin
                    if (sleep_req) begin
                        ready_ff <= 1'b0;
                        state_ff <= cssc_pkg::ST_SLEEP;
                    end else if (ost_done) begin
                        sel_ff     <= tgt_ff;
                        pending_ff <= 1'b0;
                        sw_evt_ff  <= 1'b1;
                        state_ff   <= cssc_pkg::ST_RUN;
                    end
                end
                cssc_pkg::ST_SLEEP: begin
                    if (wake_sync_ff) begin
                        tgt_ff     <= wake_tgt;
                        need_ff    <= needs_ost(wake_tgt, mode_ff);
                        ost_cnt_ff <= '0;
                        state_ff   <= cssc_pkg::ST_WAKE;
                    end
                end
                cssc_pkg::ST_WAKE: begin
                    if (ost_done) begin
                        sel_ff     <= tgt_ff;
                        ready_ff   <= 1'b1;
                        rdy_evt_ff <= 1'b1;
                        state_ff   <= cssc_pkg::ST_RUN;
                        if (pending_ff && !hold_ff) begin
                            // resume on new clock with flag
                            pending_ff <= 1'b0;
                            sw_evt_ff  <= 1'b1;
                        end else if (pending_ff) begin
                            tgt_ff     <= req_osc_ff;
                            need_ff    <= needs_ost(req_osc_ff, mode_ff);
                            ost_cnt_ff <= '0;
                            state_ff   <= cssc_pkg::ST_SWITCH;
                        end
                    end
                end
                default: begin
                    state_ff <= cssc_pkg::ST_INIT;
                end
            endcase
        end
    end

    // Clock status outputs; multiplier runs outside sleep while its source is used or awaited
    always_ff @(posedge clk) begin
        if (srst) begin
            clk_stat_ff  <= '0;
            sleep_ack_ff <= 1'b0;
        end else begin
            clk_stat_ff.sel     <= sel_ff;
            clk_stat_ff.ready   <= ready_ff;
            clk_stat_ff.pll_en  <= state_ff != cssc_pkg::ST_SLEEP
                && (sel_ff == cssc_pkg::OSC_EXT_PLL
                    || tgt_ff == cssc_pkg::OSC_EXT_PLL);
            clk_stat_ff.xtal_en <= state_ff != cssc_pkg::ST_SLEEP
                && (needs_ost(sel_ff, mode_ff) || need_ff);
            sleep_ack_ff        <= state_ff == cssc_pkg::ST_SLEEP;
        end
    end

    // Control, interrupt mask and priority registers
    always_ff @(posedge clk) begin
        if (srst) begin
            hold_ff     <= 1'b0;
            irq_mask_ff <= '0;
            prio_ff     <= cssc_pkg::PRIO_RST;
        end else if (avs_write && !wait_ff) begin
            case (avs_address)
                cssc_pkg::REG_CTRL: begin
                    hold_ff <= avs_writedata[cssc_pkg::CTRL_HOLD_BIT];
                end
                cssc_pkg::REG_IRQ_MK: begin
                    irq_mask_ff <= avs_writedata[cssc_pkg::IRQ_W-1:0];
                end
                cssc_pkg::REG_PRIO: begin
                    prio_ff <= avs_writedata[7:0] & cssc_pkg::PRIO_MASK;
                end
                default: begin
                    hold_ff <= hold_ff;
                end
            endcase
        end
    end

    // Sticky events, write one to clear; a new event beats the clear
    always_comb begin
        irq_set = '0;
        irq_set[cssc_pkg::IRQ_SWITCH] = sw_evt_ff;
        irq_set[cssc_pkg::IRQ_READY]  = rdy_evt_ff;
        irq_clr = '0;
        if (avs_write && !wait_ff && avs_address == cssc_pkg::REG_IRQ_ST) begin
            irq_clr = avs_writedata[cssc_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_stat_ff <= '0;
            irq_ff      <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
            irq_ff      <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // Bus slave: one wait cycle, then the access completes
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_ff  <= 1'b1;
            rdata_ff <= '0;
        end else begin
            wait_ff <= !(wait_ff && (avs_read || avs_write));
            if (avs_read && wait_ff) begin
                rdata_ff <= '0;
                case (avs_address)
                    cssc_pkg::REG_CTRL: begin
                        rdata_ff[cssc_pkg::CTRL_NEW_OSC_SELECT_LSB +: 3] <= req_osc_ff;
                        rdata_ff[cssc_pkg::CTRL_HOLD_BIT]      <= hold_ff;
                    end
                    cssc_pkg::REG_STAT: begin
                        rdata_ff[cssc_pkg::STAT_CUR_LSB +: 3] <= sel_ff;
                        rdata_ff[cssc_pkg::STAT_READY]   <= ready_ff;
                        rdata_ff[cssc_pkg::STAT_PENDING] <= pending_ff;
                        rdata_ff[cssc_pkg::STAT_SLEEP]   <= sleep_ack_ff;
                    end
                    cssc_pkg::REG_IRQ_ST: begin
                        rdata_ff[cssc_pkg::IRQ_W-1:0] <= irq_stat_ff;
                    end
                    cssc_pkg::REG_IRQ_MK: begin
                        rdata_ff[cssc_pkg::IRQ_W-1:0] <= irq_mask_ff;
                    end
                    cssc_pkg::REG_PRIO: begin
                        rdata_ff[7:0] <= prio_ff;
                    end
                    default: begin
                        rdata_ff <= '0;
                    end
                endcase
            end
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign clk_stat        = clk_stat_ff;
    assign sleep_ack       = sleep_ack_ff;
    assign irq_priority    = prio_ff;
    assign irq             = irq_ff;

    default clocking dcb @(posedge clk); endclocking
    default disable iff (srst);

    a_ost_full_count: assert property (
        (state_ff == cssc_pkg::ST_START && need_ff
         && ost_cnt_ff != OST_FULL)
        |=> !ready_ff && $stable(sel_ff))
        else $error("start-up ended before full count");
    a_ost_restart: assert property (
        (state_ff == cssc_pkg::ST_SLEEP && wake_sync_ff)
        |=> ost_cnt_ff == '0 && state_ff == cssc_pkg::ST_WAKE)
        else $error("start-up count not restarted on wake");
    a_pll_enable: assert property (
        (sel_ff == cssc_pkg::OSC_EXT_PLL && state_ff != cssc_pkg::ST_SLEEP)
        |=> clk_stat_ff.pll_en)
        else $error("multiplier off while selected");
    a_strap_pll: assert property (
        (state_ff == cssc_pkg::ST_INIT
         && reset_osc_select == cssc_pkg::OSC_EXT_PLL)
        |=> tgt_ff == cssc_pkg::OSC_EXT_PLL ##1 clk_stat_ff.pll_en)
        else $error("reset selection of multiplier ignored");
    a_write_pll: assert property (
        (state_ff == cssc_pkg::ST_RUN && !sleep_req && wr_ctrl
         && new_osc == cssc_pkg::OSC_EXT_PLL
         && sel_ff != cssc_pkg::OSC_EXT_PLL)
        |=> pending_ff && req_osc_ff == cssc_pkg::OSC_EXT_PLL
            && state_ff == cssc_pkg::ST_SWITCH)
        else $error("runtime multiplier request lost");
    a_sleep_abandon: assert property (
        (state_ff == cssc_pkg::ST_SWITCH && sleep_req)
        |=> state_ff == cssc_pkg::ST_SLEEP && $stable(sel_ff)
            ##1 sleep_ack_ff)
        else $error("switch not abandoned on sleep");
    a_wake_new: assert property (
        (state_ff == cssc_pkg::ST_WAKE && ost_done && pending_ff && !hold_ff)
        |=> sel_ff == $past(req_osc_ff) ##1 irq_stat_ff[cssc_pkg::IRQ_SWITCH])
        else $error("wake without hold missed new clock");
    a_wake_hold: assert property (
        (state_ff == cssc_pkg::ST_WAKE && ost_done && pending_ff && hold_ff)
        |=> $stable(sel_ff) && state_ff == cssc_pkg::ST_SWITCH
            && tgt_ff == req_osc_ff)
        else $error("held wake did not rerequest");
    a_prio_zero: assert property (
        prio_ff[5:2] == 4'h0 && irq_priority == prio_ff)
        else $error("priority reserved bits set");
    a_sel_stable: assert property (
        (state_ff == cssc_pkg::ST_SWITCH && !ost_done) |=> $stable(sel_ff))
        else $error("source changed before start-up done");
    a_bus_answer: assert property (
        (wait_ff && (avs_read || avs_write)) |=> !wait_ff ##1 wait_ff)
        else $error("bus answer timing wrong");

    c_switch_done: cover property (
        state_ff == cssc_pkg::ST_SWITCH ##1 state_ff == cssc_pkg::ST_RUN);
    c_sleep_abort: cover property (
        state_ff == cssc_pkg::ST_SWITCH && sleep_req);
    c_wake_hold: cover property (
        state_ff == cssc_pkg::ST_WAKE && ost_done && pending_ff && hold_ff);
    c_irq_out: cover property ($rose(irq_ff));

endmodule : cssc_top

// ===== inc/cssc_pkg.sv
// Purpose: Shared constants and types of the clock switch and start-up block
// Assumes: 32-bit Avalon-MM slave, byte addresses, one register per word
// Notes:   Oscillator codes are three bits wide as in the selection fields
package cssc_pkg;

    // Register byte addresses
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_STAT   = 5'h04;
    localparam logic [4:0] REG_IRQ_ST = 5'h08;
    localparam logic [4:0] REG_IRQ_MK = 5'h0c;
    localparam logic [4:0] REG_PRIO   = 5'h10;

    // Control register fields
    localparam int CTRL_NEW_OSC_SELECT_LSB = 0;
    localparam int CTRL_HOLD_BIT = 3;

    // Status register fields
    localparam int STAT_CUR_LSB  = 0;
    localparam int STAT_READY    = 4;
    localparam int STAT_PENDING  = 5;
    localparam int STAT_SLEEP    = 6;

    // Interrupt status and mask bits
    localparam int IRQ_SWITCH = 0;
    localparam int IRQ_READY  = 1;
    localparam int IRQ_W      = 2;

    // Priority register: reset value and implemented bits
    localparam logic [7:0] PRIO_RST  = 8'hc3;
    localparam logic [7:0] PRIO_MASK = 8'hc3;
    localparam int PRIO_OSC_FAIL = 7;
    localparam int PRIO_SWITCH   = 6;

    // Oscillator source codes
    localparam logic [2:0] OSC_EXT_PLL = 3'h2;
    localparam logic [2:0] OSC_HFINT   = 3'h6;
    localparam logic [2:0] OSC_EXT     = 3'h7;

    // External oscillator modes
    localparam logic [1:0] MODE_ECLK = 2'h0;
    localparam logic [1:0] MODE_LP   = 2'h1;
    localparam logic [1:0] MODE_XT   = 2'h2;
    localparam logic [1:0] MODE_HS   = 2'h3;

    // Crystal oscillations counted before the source is stable
    localparam int OST_EDGES = 1024;
    localparam int PLL_MULT  = 4;

    typedef enum logic [5:0] {
        ST_INIT   = 6'h01,
        ST_START  = 6'h02,
        ST_RUN    = 6'h04,
        ST_SWITCH = 6'h08,
        ST_SLEEP  = 6'h10,
        ST_WAKE   = 6'h20
    } cssc_state_t;

    typedef struct packed {
        logic [2:0] sel;
        logic       pll_en;
        logic       xtal_en;
        logic       ready;
    } cssc_clk_stat_t;

endpackage : cssc_pkg

// ===== tb/cssc_xtal_model.sv
// Purpose: Crystal or resonator seen at the oscillator input pin
// Assumes: Oscillates only while the block enables its crystal driver
// Notes:   Rising edge every 2*HALF clk cycles; rests low when not driven
`timescale 1ns/1ps
module cssc_xtal_model #(
    parameter int HALF = 3
) (
    input  wire logic clk,
    input  wire logic en,
    output logic      pin
);
    int   cnt_ff;
    logic pin_ff;

    // A stopped crystal gives no edges, so no count can run ahead
    always_ff @(posedge clk) begin
        if (!en) begin
            cnt_ff <= 0;
            pin_ff <= 1'b0;
        end else if (cnt_ff == HALF - 1) begin
            cnt_ff <= 0;
            pin_ff <= ~pin_ff;
        end else begin
            cnt_ff <= cnt_ff + 1;
        end
    end

    assign pin = pin_ff;
endmodule : cssc_xtal_model

// ===== tb/tb_clock_switch_startup_control.sv
// Purpose: Self-checking bench for start-up timing and clock switching
// Assumes: Avalon answer in two cycles; short start-up count of OSC_STARTUP_COUNTER edges
// Notes:   Edge counts are taken at the pin, so sync latency only adds
`timescale 1ns/1ps
module tb_clock_switch_startup_control;
    localparam int OSC_STARTUP_COUNTER   = 8;
    localparam int LIMIT = 3000;

    logic                     clk;
    logic                     srst;
    logic [4:0]               avs_address;
    logic                     avs_read;
    logic                     avs_write;
    logic [31:0]              avs_writedata;
    logic [31:0]              avs_readdata;
    logic                     avs_waitrequest;
    logic [2:0]               reset_osc_select;
    logic [1:0]               osc_mode;
    logic                     crystal_input_pin;
    logic                     sleep_req;
    logic                     wake;
    cssc_pkg::cssc_clk_stat_t clk_stat;
    logic                     sleep_ack;
    logic [7:0]               irq_priority;
    logic                     irq;
    int                       mismatches;
    int                       samples_checked;
    int                       edges = 0;
    int                       e0;

    cssc_top #(.OST_EDGES(OSC_STARTUP_COUNTER)) uut (
        .clk(clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .reset_osc_select(reset_osc_select), .osc_mode(osc_mode),
        .crystal_input_pin(crystal_input_pin), .sleep_req(sleep_req),
        .wake(wake), .clk_stat(clk_stat), .sleep_ack(sleep_ack),
        .irq_priority(irq_priority), .irq(irq)
    );

    cssc_xtal_model xtal (
        .clk(clk), .en(clk_stat.xtal_en), .pin(crystal_input_pin)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge crystal_input_pin) edges++;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic fail(input string msg);
        mismatches++;
        $display("Error at %0t: %s", $time, msg);
    endtask : fail

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
    endtask : chk_reg

    task automatic chk_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
    endtask : chk_flag

    // Request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail("bus timeout");
            print_verdict();
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk_reg(q, exp);
    endtask : rd_chk

    function automatic bit met(input int k, input logic [2:0] s);
        case (k)
            0: return clk_stat.sel === s;
            1: return sleep_ack === 1'b1;
            default: return sleep_ack === 1'b0;
        endcase
    endfunction : met

    task automatic wait_on(input int k, input logic [2:0] s);
        int n;
        n = 0;
        while (!met(k, s) && n < LIMIT) begin
            @(posedge clk);
            n++;
        end
        if (n >= LIMIT) begin
            fail("wait timeout");
            print_verdict();
        end
    endtask : wait_on

    task automatic sleep_wake();
        sleep_req <= 1'b0;
        e0 = edges;
        wake <= 1'b1;
        wait_on(2, 3'h0);
        wake <= 1'b0;
    endtask : sleep_wake

    initial begin
        avs_address      = 5'h00;
        avs_read         = 1'b0;
        avs_write        = 1'b0;
        avs_writedata    = 32'h0;
        reset_osc_select = cssc_pkg::OSC_EXT_PLL;
        osc_mode         = cssc_pkg::MODE_XT;
        sleep_req        = 1'b0;
        wake             = 1'b0;
        srst             = 1'b1;
        mismatches       = 0;
        samples_checked  = 0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk_reg({24'h0, irq_priority}, {24'h0, cssc_pkg::PRIO_RST});
        chk_flag(avs_waitrequest, 1'b1);
        wait_on(0, cssc_pkg::OSC_EXT_PLL);
        chk_flag(edges >= OSC_STARTUP_COUNTER, 1'b1);
        chk_flag(clk_stat.pll_en, 1'b1);
        chk_flag(clk_stat.ready, 1'b1);
        chk_flag(clk_stat.xtal_en, 1'b1);
        rd_chk(cssc_pkg::REG_STAT, 32'h12);
        $display("test reset start done");

        rd_chk(cssc_pkg::REG_PRIO, 32'hc3);
        wr(cssc_pkg::REG_PRIO, 32'hff);
        rd_chk(cssc_pkg::REG_PRIO, 32'hc3);
        wr(cssc_pkg::REG_PRIO, 32'h3c);
        rd_chk(cssc_pkg::REG_PRIO, 32'h00);
        chk_reg({24'h0, irq_priority}, 32'h0);
        wr(cssc_pkg::REG_PRIO, 32'h81);
        rd_chk(cssc_pkg::REG_PRIO, 32'h81);
        wr(5'h14, 32'hffffffff);
        rd_chk(5'h14, 32'h0);
        $display("test registers done");

        rd_chk(cssc_pkg::REG_IRQ_ST, 32'h2);
        wr(cssc_pkg::REG_IRQ_MK, 32'h0);
        repeat (3) @(posedge clk);
        chk_flag(irq, 1'b0);
        wr(cssc_pkg::REG_IRQ_MK, 32'h2);
        repeat (3) @(posedge clk);
        chk_flag(irq, 1'b1);
        wr(cssc_pkg::REG_IRQ_ST, 32'h2);
        repeat (3) @(posedge clk);
        chk_flag(irq, 1'b0);
        rd_chk(cssc_pkg::REG_IRQ_ST, 32'h0);
        wr(cssc_pkg::REG_IRQ_MK, 32'h3);
        $display("test interrupt done");

        wr(cssc_pkg::REG_CTRL, {29'h0, cssc_pkg::OSC_HFINT});
        wait_on(0, cssc_pkg::OSC_HFINT);
        rd_chk(cssc_pkg::REG_IRQ_ST, 32'h1);
        wr(cssc_pkg::REG_IRQ_ST, 32'h3);
        e0 = edges;
        wr(cssc_pkg::REG_CTRL, {29'h0, cssc_pkg::OSC_EXT_PLL});
        wait_on(0, cssc_pkg::OSC_EXT_PLL);
        chk_flag(edges - e0 >= OSC_STARTUP_COUNTER, 1'b1);
        chk_flag(clk_stat.pll_en, 1'b1);
        $display("test runtime switch done");

        wr(cssc_pkg::REG_CTRL, {29'h0, cssc_pkg::OSC_HFINT});
        wait_on(0, cssc_pkg::OSC_HFINT);
        wr(cssc_pkg::REG_IRQ_ST, 32'h3);
        wr(cssc_pkg::REG_CTRL, {29'h0, cssc_pkg::OSC_EXT});
        sleep_req <= 1'b1;
        wait_on(1, 3'h0);
        chk_reg({29'h0, clk_stat.sel}, {29'h0, cssc_pkg::OSC_HFINT});
        sleep_wake();
        wait_on(0, cssc_pkg::OSC_EXT);
        chk_flag(edges - e0 >= OSC_STARTUP_COUNTER, 1'b1);
        rd_chk(cssc_pkg::REG_IRQ_ST, 32'h3);
        wr(cssc_pkg::REG_IRQ_ST, 32'h3);
        $display("test sleep without hold done");

        wr(cssc_pkg::REG_CTRL, 32'h8 | {29'h0, cssc_pkg::OSC_EXT_PLL});
        sleep_req <= 1'b1;
        wait_on(1, 3'h0);
        chk_reg({29'h0, clk_stat.sel}, {29'h0, cssc_pkg::OSC_EXT});
        rd_chk(cssc_pkg::REG_STAT, 32'h67);
        rd_chk(cssc_pkg::REG_CTRL, 32'ha);
        sleep_wake();
        chk_reg({29'h0, clk_stat.sel}, {29'h0, cssc_pkg::OSC_EXT});
        wait_on(0, cssc_pkg::OSC_EXT_PLL);
        chk_flag(edges - e0 >= 2 * OSC_STARTUP_COUNTER, 1'b1);
        $display("test sleep with hold done");

        // Mid-run reset with a plain external clock: no start-up count
        osc_mode <= cssc_pkg::MODE_ECLK;
        srst     <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        e0 = edges;
        @(posedge clk);
        chk_reg({24'h0, irq_priority}, {24'h0, cssc_pkg::PRIO_RST});
        wait_on(0, cssc_pkg::OSC_EXT_PLL);
        chk_flag(edges == e0, 1'b1);
        chk_flag(clk_stat.xtal_en, 1'b0);
        chk_flag(clk_stat.pll_en, 1'b1);
        $display("test external clock reset done");
        print_verdict();
    end
endmodule : tb_clock_switch_startup_control
